// >>> hw/icsr_top.sv
// Inter-processor shared registers: cycle counter, clusters, semaphores
//
// Function
// R1: One shared 64-bit cycle counter advancing by one every clock.
// R2: Counter loaded from a processor scalar, or returned to it on read.
// R3: Counter loads and reads from all processors complete together, unblocked.
// R4: Simultaneous counter loads: lowest-numbered processor wins, counting resumes.
// R5: Five sets, each eight 24-bit address, eight 64-bit scalar, 32 semaphores.
// R6: Per-processor cluster select, loaded from context or monitor-only instruction.
// R7: Cluster values one to five select a set; zero denies access.
// R8: Cluster zero: shared operations do nothing, reads return zero.
// R9: Processors with equal nonzero cluster share one register set.
// R10: No reservations on shared registers; one access per clock.
// R11: Address registers and scalar registers written and read by instructions.
// R12: Semaphores loaded, read, set, cleared anytime by any processor.
// R13: Test-and-set issues and sets a zero semaphore, else holds.
// R14: Test-and-set interlocked; never two completions on one semaphore together.
// R15: All processors of a cluster holding test-and-set raise deadlock.
// R16: Single-member cluster holding test-and-set gets deadlock.
// R17: Cluster zero never gets deadlock.
// R18: Processor lets staged instructions issue before ordinary interrupt switch.
// R19: Interrupt during held test-and-set discards it for later retry.
// R20: That case sets the waiting-on-semaphore flag for the saved context.
// R21: Clear, set and whole-group semaphore transfers supported.
// R22: Four-slot scanner breaks ties; no extra hold without competition.
// R23: Shared read holds three clocks; requests accepted every other clock.
`timescale 1ns/1ps
`default_nettype none
module icsr_top (
  input wire logic CLK_I,
  input wire logic RESETN_I,
  input wire logic [icsr_pkg::ICSR_NCPU-1:0] REQ_VALID_I,
  input wire icsr_pkg::icsr_op_t REQ_OP_I [icsr_pkg::ICSR_NCPU],
  input wire logic [icsr_pkg::ICSR_IW-1:0] REQ_IDX_I [icsr_pkg::ICSR_NCPU],
  input wire logic [icsr_pkg::ICSR_DW-1:0] REQ_WDATA_I [icsr_pkg::ICSR_NCPU],
  input wire logic [icsr_pkg::ICSR_NCPU-1:0] MONITOR_I,
  input wire logic [icsr_pkg::ICSR_NCPU-1:0] CTX_CLN_WE_I,
  input wire logic [icsr_pkg::ICSR_CLW-1:0] CTX_CLN_I [icsr_pkg::ICSR_NCPU],
  input wire logic [icsr_pkg::ICSR_NCPU-1:0] INTR_I,
  output logic [icsr_pkg::ICSR_NCPU-1:0] ACK_O,
  output logic [icsr_pkg::ICSR_NCPU-1:0] BUSY_O,
  output logic [icsr_pkg::ICSR_DW-1:0] RDATA_O [icsr_pkg::ICSR_NCPU],
  output logic [icsr_pkg::ICSR_NCPU-1:0] DEADLOCK_O,
  output logic [icsr_pkg::ICSR_NCPU-1:0] WAITING_ON_SEM_FLAG_O,
  output logic [icsr_pkg::ICSR_CLW-1:0] CLUSTER_SELECT_O [icsr_pkg::ICSR_NCPU]
);
  import icsr_pkg::*;

  // ==========================================================================
  // Declarations
  logic [ICSR_DW-1:0] counter_r;
  logic [ICSR_CLW-1:0] cluster_select_r [ICSR_NCPU];
  logic [ICSR_NCPU-1:0] pend_r;
  logic [ICSR_NCPU-1:0] busy_r;
  logic [ICSR_NCPU-1:0] ack_r;
  logic [ICSR_NCPU-1:0] ws_r;
  logic [ICSR_NCPU-1:0] dl_r;
  icsr_op_t op_r [ICSR_NCPU];
  logic [ICSR_IW-1:0] idx_r [ICSR_NCPU];
  logic [ICSR_DW-1:0] wd_r [ICSR_NCPU];
  logic [1:0] cnt_r [ICSR_NCPU];
  logic [ICSR_DW-1:0] rdata_r [ICSR_NCPU];
  logic [ICSR_NCPU-1:0] take;
  logic [ICSR_NCPU-1:0] member_ok;
  logic [ICSR_NCPU-1:0] gnt_cpu;
  logic [ICSR_NCPU-1:0] holding_ts;
  logic [ICSR_NCPU-1:0] abort_ts;
  logic [ICSR_NCPU-1:0] grant [ICSR_NCLU];
  logic [ICSR_NCPU-1:0] scan_req [ICSR_NCLU];
  logic [ICSR_DW-1:0] clu_rd [ICSR_NCLU];
  logic [ICSR_NSEM-1:0] clu_sem [ICSR_NCLU];
  logic [ICSR_NCLU-1:0] clu_dead;
  logic [ICSR_NCPU-1:0] cpu_dead;

  // ==========================================================================
  // Helpers
  function automatic logic cln_valid(input logic [ICSR_CLW-1:0] c);
    return (c >= ICSR_CLN_MIN) && (c <= ICSR_CLN_MAX);
  endfunction : cln_valid

  function automatic logic is_local(input icsr_op_t op);
    return (op == ICSR_CNT_LOAD) || (op == ICSR_CNT_READ) ||
           (op == ICSR_CLN_LOAD) || (op == ICSR_NOP);
  endfunction : is_local

  // ==========================================================================
  // Outputs
  assign ACK_O = ack_r;
  assign BUSY_O = busy_r;
  assign RDATA_O = rdata_r;
  assign DEADLOCK_O = dl_r;
  assign WAITING_ON_SEM_FLAG_O = ws_r;
  assign CLUSTER_SELECT_O = cluster_select_r;
  assign take = REQ_VALID_I & ~busy_r;

  // ==========================================================================
  // Cycle counter
  always_ff @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
      counter_r <= ICSR_CNT_RST;
    else
    begin
      counter_r <= counter_r + 64'h1; // R1
      for (int i = ICSR_NCPU - 1; i >= 0; i--)
      begin
        if (take[i] && REQ_OP_I[i] == ICSR_CNT_LOAD)
          counter_r <= REQ_WDATA_I[i]; // R2 R4
      end
    end
  end

  // ==========================================================================
  // Per-processor logic
  for (genvar i = 0; i < ICSR_NCPU; i++)
  begin : g_cpu
    assign member_ok[i] = cln_valid(cluster_select_r[i]); // R7

    // Cluster select
    always_ff @(posedge CLK_I or negedge RESETN_I)
    begin
      if (!RESETN_I)
        cluster_select_r[i] <= ICSR_CLN_RST;
      else if (CTX_CLN_WE_I[i])
        cluster_select_r[i] <= CTX_CLN_I[i]; // R6
      else if (take[i] && REQ_OP_I[i] == ICSR_CLN_LOAD && MONITOR_I[i])
        cluster_select_r[i] <= REQ_WDATA_I[i][ICSR_CLW-1:0]; // R6
    end

    // Grant and hold status
    always_comb
    begin
      gnt_cpu[i] = 1'b0;
      for (int c = 0; c < ICSR_NCLU; c++)
        gnt_cpu[i] = gnt_cpu[i] | grant[c][i];
    end
    assign holding_ts[i] = pend_r[i] && op_r[i] == ICSR_TEST_AND_SET_OP
                           && !gnt_cpu[i]; // R13
    assign abort_ts[i] = holding_ts[i] && INTR_I[i]; // R18 R19

    // Request latch
    always_ff @(posedge CLK_I or negedge RESETN_I)
    begin
      if (!RESETN_I)
      begin
        op_r[i] <= ICSR_NOP;
        idx_r[i] <= '0;
        wd_r[i] <= '0;
      end
      else if (take[i])
      begin
        op_r[i] <= REQ_OP_I[i];
        idx_r[i] <= REQ_IDX_I[i];
        wd_r[i] <= REQ_WDATA_I[i];
      end
    end

    // Issue sequencing
    always_ff @(posedge CLK_I or negedge RESETN_I)
    begin
      if (!RESETN_I)
      begin
        pend_r[i] <= 1'b0;
        busy_r[i] <= 1'b0;
        ack_r[i] <= 1'b0;
        cnt_r[i] <= 2'h0;
        rdata_r[i] <= '0;
      end
      else
      begin
        ack_r[i] <= 1'b0;
        if (take[i])
        begin
          if (is_local(REQ_OP_I[i]))
          begin
            ack_r[i] <= 1'b1; // R3
            if (REQ_OP_I[i] == ICSR_CNT_READ)
              rdata_r[i] <= counter_r; // R2
            else
              rdata_r[i] <= '0;
          end
          else if (!member_ok[i])
          begin
            ack_r[i] <= 1'b1; // R8
            rdata_r[i] <= '0; // R8
          end
          else
          begin
            pend_r[i] <= 1'b1;
            busy_r[i] <= 1'b1;
          end
        end
        else if (abort_ts[i])
        begin
          pend_r[i] <= 1'b0; // R19
          busy_r[i] <= 1'b0;
        end
        else if (pend_r[i] && gnt_cpu[i])
        begin
          pend_r[i] <= 1'b0;
          cnt_r[i] <= ICSR_HOLD_LOAD; // R23
          rdata_r[i] <= clu_rd[cluster_select_r[i] - ICSR_CLN_MIN]; // R11
        end
        else if (cnt_r[i] != 2'h0)
        begin
          cnt_r[i] <= cnt_r[i] - 2'h1;
          if (cnt_r[i] == 2'h1)
          begin
            ack_r[i] <= 1'b1; // R23
            busy_r[i] <= 1'b0;
          end
        end
      end
    end

    // Waiting-on-semaphore pulse
    always_ff @(posedge CLK_I or negedge RESETN_I)
    begin
      if (!RESETN_I)
        ws_r[i] <= 1'b0;
      else
        ws_r[i] <= abort_ts[i]; // R20
    end

    // Deadlock per processor
    always_comb
    begin
      cpu_dead[i] = 1'b0;
      for (int c = 0; c < ICSR_NCLU; c++)
      begin
        if (cluster_select_r[i] == ICSR_CLW'(c + 1))
          cpu_dead[i] = clu_dead[c]; // R15 R16
      end
    end

    always_ff @(posedge CLK_I or negedge RESETN_I)
    begin
      if (!RESETN_I)
        dl_r[i] <= 1'b0;
      else
        dl_r[i] <= member_ok[i] && cpu_dead[i]; // R17
    end
  end

  // ==========================================================================
  // Shared register sets
  for (genvar c = 0; c < ICSR_NCLU; c++)
  begin : g_clu
    icsr_acc_if acc ();

    // Requests routed to this set
    always_comb
    begin
      scan_req[c] = '0;
      for (int i = 0; i < ICSR_NCPU; i++)
      begin
        if (pend_r[i] && cluster_select_r[i] == ICSR_CLW'(c + 1)) // R9
        begin
          if (op_r[i] != ICSR_TEST_AND_SET_OP)
            scan_req[c][i] = 1'b1;
          else if (!clu_sem[c][idx_r[i]])
            scan_req[c][i] = 1'b1; // R13
        end
      end
    end

    icsr_scan #(
      .N(ICSR_NCPU)
    ) u_scan (
      .clk_i(CLK_I),
      .rst_n_i(RESETN_I),
      .req_i(scan_req[c]),
      .grant_o(grant[c])
    ); // R10 R14 R22

    // Granted request onto the set
    always_comb
    begin
      acc.en = 1'b0;
      acc.op = ICSR_NOP;
      acc.idx = '0;
      acc.wd = '0;
      for (int i = 0; i < ICSR_NCPU; i++)
      begin
        if (grant[c][i])
        begin
          acc.en = 1'b1; // R10
          acc.op = op_r[i];
          acc.idx = idx_r[i];
          acc.wd = wd_r[i]; // R11 R12 R21
        end
      end
    end

    icsr_regs u_regs (
      .clk_i(CLK_I),
      .rst_n_i(RESETN_I),
      .acc(acc)
    ); // R5

    assign clu_rd[c] = acc.rd;
    assign clu_sem[c] = acc.sem;

    // All members holding on test-and-set
    always_comb
    begin
      logic any;
      logic all;
      any = 1'b0;
      all = 1'b1;
      for (int i = 0; i < ICSR_NCPU; i++)
      begin
        if (cluster_select_r[i] == ICSR_CLW'(c + 1))
        begin
          any = 1'b1;
          all = all & holding_ts[i];
        end
      end
      clu_dead[c] = any & all; // R15 R16
    end
  end

endmodule : icsr_top
`default_nettype wire

// >>> hw/icsr_pkg.sv
// Shared constants and types of the inter-processor shared register block
package icsr_pkg;
  // ==========================================================================
  // Sizes
  localparam int ICSR_NCPU = 4;
  localparam int ICSR_NCLU = 5;
  localparam int ICSR_NSA = 8;
  localparam int ICSR_NSEM = 32;
  localparam int ICSR_AW = 24;
  localparam int ICSR_DW = 64;
  localparam int ICSR_CLW = 3;
  localparam int ICSR_IW = 5;
  // ==========================================================================
  // Cycle counts
  localparam int ICSR_HOLD_CP = 3;
  localparam int ICSR_REQ_CP = 2;
  localparam logic [1:0] ICSR_HOLD_LOAD = 2'(ICSR_HOLD_CP - 1);
  // ==========================================================================
  // Reset values and cluster range
  localparam logic [63:0] ICSR_CNT_RST = 64'h0;
  localparam logic [2:0] ICSR_CLN_RST = 3'h0;
  localparam logic [31:0] ICSR_SEM_RST = 32'h0;
  localparam logic [2:0] ICSR_CLN_MIN = 3'h1;
  localparam logic [2:0] ICSR_CLN_MAX = 3'h5;
  // ==========================================================================
  // Operations
  typedef enum logic [3:0] {
    ICSR_NOP,
    ICSR_CNT_LOAD,
    ICSR_CNT_READ,
    ICSR_CLN_LOAD,
    ICSR_SA_WR,
    ICSR_SA_RD,
    ICSR_SS_WR,
    ICSR_SS_RD,
    ICSR_TEST_AND_SET_OP,
    ICSR_SEM_CLR,
    ICSR_SEM_SET,
    ICSR_SEM_RD,
    ICSR_SEM_WR
  } icsr_op_t;
endpackage : icsr_pkg

// >>> hw/icsr_acc_if.sv
// Access path between the arbiter and one shared register set
`timescale 1ns/1ps
`default_nettype none
interface icsr_acc_if;
  import icsr_pkg::*;
  logic en;
  icsr_op_t op;
  logic [ICSR_IW-1:0] idx;
  logic [ICSR_DW-1:0] wd;
  logic [ICSR_DW-1:0] rd;
  logic [ICSR_NSEM-1:0] sem;
  modport host_mp (output en, op, idx, wd, input rd, sem);
  modport regs_mp (input en, op, idx, wd, output rd, sem);
endinterface : icsr_acc_if
`default_nettype wire

// >>> hw/icsr_scan.sv
// Four-slot rotating scanner granting one request every other cycle
`timescale 1ns/1ps
`default_nettype none
module icsr_scan #(
  parameter int N = 4
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [N-1:0] req_i,
  output logic [N-1:0] grant_o
);
  localparam int PW = $clog2(N);
  logic [PW-1:0] ptr_r;
  logic [PW-1:0] ptr_nxt;
  logic busy_r;
  // ==========================================================================
  // Slot search from pointer
  always_comb
  begin
    int j;
    logic found;
    j = 0;
    found = 1'b0;
    grant_o = '0;
    ptr_nxt = ptr_r;
    if (!busy_r)
    begin
      for (int k = 0; k < N; k++)
      begin
        j = (int'(ptr_r) + k) % N;
        if (!found && req_i[j])
        begin
          found = 1'b1;
          grant_o[j] = 1'b1;
          ptr_nxt = PW'((j + 1) % N);
        end
      end
    end
  end
  // ==========================================================================
  // Two-cycle occupancy
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ptr_r <= '0;
      busy_r <= 1'b0;
    end
    else
    begin
      ptr_r <= ptr_nxt;
      busy_r <= |grant_o;
    end
  end
endmodule : icsr_scan
`default_nettype wire

// >>> hw/icsr_regs.sv
// One shared register set: address, scalar and semaphore registers
`timescale 1ns/1ps
`default_nettype none
module icsr_regs (
  input wire logic clk_i,
  input wire logic rst_n_i,
  icsr_acc_if.regs_mp acc
);
  import icsr_pkg::*;
  logic [ICSR_AW-1:0] shared_address_r [ICSR_NSA];
  logic [ICSR_DW-1:0] shared_scalar_r [ICSR_NSA];
  logic [ICSR_NSEM-1:0] semaphore_bit_r;
  logic [2:0] ri;
  assign ri = acc.idx[2:0];
  assign acc.sem = semaphore_bit_r;
  // ==========================================================================
  // Data registers
  always_ff @(posedge clk_i)
  begin
    if (acc.en && acc.op == ICSR_SA_WR)
      shared_address_r[ri] <= acc.wd[ICSR_AW-1:0];
    if (acc.en && acc.op == ICSR_SS_WR)
      shared_scalar_r[ri] <= acc.wd;
  end
  // ==========================================================================
  // Semaphores
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      semaphore_bit_r <= ICSR_SEM_RST;
    else if (acc.en)
    begin
      case (acc.op)
        ICSR_TEST_AND_SET_OP: semaphore_bit_r[acc.idx] <= 1'b1;
        ICSR_SEM_SET: semaphore_bit_r[acc.idx] <= 1'b1;
        ICSR_SEM_CLR: semaphore_bit_r[acc.idx] <= 1'b0;
        ICSR_SEM_WR: semaphore_bit_r <= acc.wd[ICSR_NSEM-1:0];
        default: ;
      endcase
    end
  end
  // ==========================================================================
  // Read return
  always_comb
  begin
    case (acc.op)
      ICSR_SA_RD: acc.rd = {{(ICSR_DW-ICSR_AW){1'b0}}, shared_address_r[ri]};
      ICSR_SS_RD: acc.rd = shared_scalar_r[ri];
      ICSR_SEM_RD: acc.rd = {{(ICSR_DW-ICSR_NSEM){1'b0}}, semaphore_bit_r};
      default: acc.rd = '0;
    endcase
  end
endmodule : icsr_regs
`default_nettype wire

// >>> tb/icsr_props.sv
// Port checker for the shared register block
`timescale 1ns/1ps
`default_nettype none
module icsr_props (
  input wire logic CLK_I,
  input wire logic RESETN_I,
  input wire logic [icsr_pkg::ICSR_NCPU-1:0] REQ_VALID_I,
  input wire icsr_pkg::icsr_op_t REQ_OP_I [icsr_pkg::ICSR_NCPU],
  input wire logic [icsr_pkg::ICSR_NCPU-1:0] MONITOR_I,
  input wire logic [icsr_pkg::ICSR_NCPU-1:0] CTX_CLN_WE_I,
  input wire logic [icsr_pkg::ICSR_NCPU-1:0] INTR_I,
  input wire logic [icsr_pkg::ICSR_NCPU-1:0] ACK_O,
  input wire logic [icsr_pkg::ICSR_NCPU-1:0] BUSY_O,
  input wire logic [icsr_pkg::ICSR_DW-1:0] RDATA_O [icsr_pkg::ICSR_NCPU],
  input wire logic [icsr_pkg::ICSR_NCPU-1:0] DEADLOCK_O,
  input wire logic [icsr_pkg::ICSR_NCPU-1:0] WAITING_ON_SEM_FLAG_O,
  input wire logic [icsr_pkg::ICSR_CLW-1:0] CLUSTER_SELECT_O [icsr_pkg::ICSR_NCPU]
);
  import icsr_pkg::*;
  // ==========================================================================
  // Helpers
  logic t0, sh0, quiet, tsw, ld, rd_r, ld_r, ts_r;
  assign t0 = REQ_VALID_I[0] && !BUSY_O[0];
  assign sh0 = REQ_OP_I[0] >= ICSR_SA_WR && REQ_OP_I[0] != ICSR_TEST_AND_SET_OP
    && CLUSTER_SELECT_O[0] inside {[ICSR_CLN_MIN:ICSR_CLN_MAX]};
  assign quiet = ~|(BUSY_O[3:1] | REQ_VALID_I[3:1]);
  assign tsw = BUSY_O[2] && ts_r && CLUSTER_SELECT_O[2] == 3'h2 && CLUSTER_SELECT_O[0] != 3'h2
    && CLUSTER_SELECT_O[1] != 3'h2 && CLUSTER_SELECT_O[3] != 3'h2;
  always_comb
  begin
    ld = 1'b0;
    for (int i = 0; i < ICSR_NCPU; i++)
      ld |= REQ_VALID_I[i] && !BUSY_O[i] && REQ_OP_I[i] == ICSR_CNT_LOAD;
  end
  always_ff @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      rd_r <= 1'b0;
      ld_r <= 1'b0;
      ts_r <= 1'b0;
    end
    else
    begin
      rd_r <= t0 && REQ_OP_I[0] == ICSR_CNT_READ;
      ld_r <= ld;
      if (REQ_VALID_I[2] && !BUSY_O[2])
        ts_r <= REQ_OP_I[2] == ICSR_TEST_AND_SET_OP;
    end
  end
  // ==========================================================================
  // Properties
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);
  property p_cnt_inc;
    rd_r && $past(rd_r, 2) && !$past(ld_r) && !$past(ld_r, 2)
      |-> RDATA_O[0] == $past(RDATA_O[0], 2) + 64'h2;
  endproperty
  a_cnt_inc: assert property (p_cnt_inc) else $error("counter step wrong");
  for (genvar i = 0; i < ICSR_NCPU; i++)
  begin : g_loc
    property p_local_ack;
      REQ_VALID_I[i] && !BUSY_O[i] && REQ_OP_I[i] inside {ICSR_CNT_LOAD, ICSR_CNT_READ}
        |=> ACK_O[i] && !BUSY_O[i];
    endproperty
    a_local_ack: assert property (p_local_ack) else $error("counter op blocked");
  end
  property p_cln0;
    REQ_VALID_I[3] && !BUSY_O[3] && CLUSTER_SELECT_O[3] == 3'h0 && REQ_OP_I[3] >= ICSR_SA_WR
      |=> ACK_O[3] && RDATA_O[3] == 64'h0;
  endproperty
  a_cln0: assert property (p_cln0) else $error("denied access not void");
  property p_cln_mon;
    t0 && REQ_OP_I[0] == ICSR_CLN_LOAD && !MONITOR_I[0] && !CTX_CLN_WE_I[0]
      ##1 !CTX_CLN_WE_I[0] && !REQ_VALID_I[0]
      |-> $stable(CLUSTER_SELECT_O[0]) ##1 $stable(CLUSTER_SELECT_O[0]);
  endproperty
  a_cln_mon: assert property (p_cln_mon) else $error("cluster loaded outside monitor");
  property p_no_dl0;
    DEADLOCK_O[3] |-> $past(CLUSTER_SELECT_O[3]) != 3'h0;
  endproperty
  a_no_dl0: assert property (p_no_dl0) else $error("deadlock in cluster zero");
  property p_dl_single;
    tsw [*6] |-> DEADLOCK_O[2];
  endproperty
  a_dl_single: assert property (p_dl_single) else $error("single member no deadlock");
  property p_ts_abort;
    tsw [*6] ##0 INTR_I[2] |=> !BUSY_O[2] && !ACK_O[2] ##[0:1] WAITING_ON_SEM_FLAG_O[2];
  endproperty
  a_ts_abort: assert property (p_ts_abort) else $error("held op not dropped");
  property p_sa_uncont;
    t0 && sh0 && quiet |=> !ACK_O[0] [*3] ##1 ACK_O[0];
  endproperty
  a_sa_uncont: assert property (p_sa_uncont) else $error("uncontended hold wrong");
  property p_sh_bound;
    t0 && sh0 |=> (BUSY_O[0] && !ACK_O[0]) [*3] ##[1:16] ACK_O[0];
  endproperty
  a_sh_bound: assert property (p_sh_bound) else $error("shared op latency wrong");
  c_dl: cover property (DEADLOCK_O[2]);
  c_abort: cover property (WAITING_ON_SEM_FLAG_O[2]);
  c_two: cover property (BUSY_O[0] && BUSY_O[1]);
endmodule : icsr_props
bind icsr_top icsr_props u_props (.CLK_I, .RESETN_I, .REQ_VALID_I, .REQ_OP_I, .MONITOR_I,
  .CTX_CLN_WE_I, .INTR_I, .ACK_O, .BUSY_O, .RDATA_O, .DEADLOCK_O, .WAITING_ON_SEM_FLAG_O,
  .CLUSTER_SELECT_O);
`default_nettype wire

// >>> tb/icsr_cpu_model.sv
// Request model of the four processors
`timescale 1ns/1ps
`default_nettype none
module icsr_cpu_model (
  input wire logic clk_i,
  input wire logic [3:0] busy_i,
  input wire logic [3:0] ack_i,
  output logic [3:0] valid_o,
  output icsr_pkg::icsr_op_t op_o [4],
  output logic [4:0] idx_o [4],
  output logic [63:0] wd_o [4]
);
  import icsr_pkg::*;
  initial
  begin
    valid_o = 4'h0;
    op_o = '{default: ICSR_NOP};
    idx_o = '{default: 5'h0};
    wd_o = '{default: 64'h0};
  end
  // ==========================================================================
  // One instruction: wait until free, strobe one cycle, await answer
  task automatic issue(input int c, input icsr_op_t o, input logic [4:0] i,
    input logic [63:0] d);
    @(posedge clk_i);
    #2;
    while (busy_i[c] !== 1'b0)
    begin
      @(posedge clk_i);
      #2;
    end
    valid_o[c] = 1'b1;
    op_o[c] = o;
    idx_o[c] = i;
    wd_o[c] = d;
    @(posedge clk_i);
    #2;
    valid_o[c] = 1'b0;
    idx_o[c] = ~i;
    wd_o[c] = ~d;
    for (int n = 0; n < 60 && ack_i[c] !== 1'b1 && busy_i[c] !== 1'b0; n++)
    begin
      @(posedge clk_i);
      #2;
    end
  endtask : issue
endmodule : icsr_cpu_model
`default_nettype wire

// >>> tb/inter_cpu_shared_regs_test.sv
// Self-checking bench for the shared register block
`timescale 1ns/1ps
`default_nettype none
module inter_cpu_shared_regs_test;
  import icsr_pkg::*;
  logic clk;
  logic rst_n;
  logic [3:0] valid, mon, cwe, intr, ack, busy, dl, ws;
  icsr_op_t op [4];
  logic [4:0] idx [4];
  logic [63:0] wd [4];
  logic [63:0] rd [4];
  logic [2:0] ccl [4];
  logic [2:0] cls [4];
  logic [63:0] v, w, ta, tb;
  int error_cnt, cmp_count, ws_n;
  icsr_top u_dut (.CLK_I(clk), .RESETN_I(rst_n), .REQ_VALID_I(valid), .REQ_OP_I(op),
    .REQ_IDX_I(idx), .REQ_WDATA_I(wd), .MONITOR_I(mon), .CTX_CLN_WE_I(cwe), .CTX_CLN_I(ccl),
    .INTR_I(intr), .ACK_O(ack), .BUSY_O(busy), .RDATA_O(rd), .DEADLOCK_O(dl),
    .WAITING_ON_SEM_FLAG_O(ws), .CLUSTER_SELECT_O(cls));
  icsr_cpu_model u_cpu (.clk_i(clk), .busy_i(busy), .ack_i(ack), .valid_o(valid), .op_o(op),
    .idx_o(idx), .wd_o(wd));
  // ==========================================================================
  // Tasks
  task automatic cmp(input string what, input logic [63:0] exp, input logic [63:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic go(input int c, input icsr_op_t o, input logic [4:0] i, input logic [63:0] d);
    u_cpu.issue(c, o, i, d);
    cmp("answer", 64'h0, 64'(busy[c]));
  endtask : go
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  // ==========================================================================
  // Clock, flags, watchdog
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk)
    if (rst_n)
      ws_n <= ws_n + $countones(ws);
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    final_report();
  end
  // ==========================================================================
  // Tests
  initial
  begin
    rst_n = 1'b0;
    mon = 4'h0;
    cwe = 4'h0;
    intr = 4'h0;
    ccl = '{default: 3'h0};
    void'($urandom(32'hA4E7));
    repeat (12) @(posedge clk);
    #2;
    rst_n = 1'b1;
    ccl = '{3'h1, 3'h1, 3'h2, 3'h0};
    cwe = 4'hF;
    @(posedge clk);
    #2;
    cwe = 4'h0;
    go(0, ICSR_CLN_LOAD, 5'h0, 64'h4);
    for (int i = 0; i < 4; i++)
      cmp("cluster", 64'(ccl[i]), 64'(cls[i]));
    mon = 4'h1;
    go(0, ICSR_CLN_LOAD, 5'h0, 64'h4);
    go(0, ICSR_NOP, 5'h0, 64'h0);
    cmp("cluster monitor", 64'h4, 64'(cls[0]));
    go(0, ICSR_CLN_LOAD, 5'h0, 64'h1);
    mon = 4'h0;
    $display("test cluster done");
    go(0, ICSR_CNT_READ, 5'h0, 64'h0);
    v = rd[0];
    go(0, ICSR_CNT_READ, 5'h0, 64'h0);
    cmp("counter step", v + 64'h2, rd[0]);
    v = {$urandom, $urandom};
    fork
      go(2, ICSR_CNT_LOAD, 5'h0, ~v);
      go(1, ICSR_CNT_LOAD, 5'h0, v);
    join
    fork
      go(0, ICSR_CNT_READ, 5'h0, 64'h0);
      go(1, ICSR_CNT_READ, 5'h0, 64'h0);
      go(2, ICSR_CNT_READ, 5'h0, 64'h0);
      go(3, ICSR_CNT_READ, 5'h0, 64'h0);
    join
    for (int i = 0; i < 4; i++)
      cmp("counter load", v + 64'h1, rd[i]);
    $display("test counter done");
    go(3, ICSR_SA_WR, 5'h2, v);
    go(3, ICSR_SA_RD, 5'h2, 64'h0);
    cmp("cluster zero read", 64'h0, rd[3]);
    for (int i = 0; i < 6; i++)
    begin
      v = {$urandom, $urandom};
      w = 64'($urandom_range(7));
      go(2, (i % 2) ? ICSR_SS_WR : ICSR_SA_WR, w[4:0], ~v);
      go(0, (i % 2) ? ICSR_SS_WR : ICSR_SA_WR, w[4:0], v);
      go(1, (i % 2) ? ICSR_SS_RD : ICSR_SA_RD, w[4:0], 64'h0);
      cmp("shared reg", (i % 2) ? v : {40'h0, v[23:0]}, rd[1]);
      go(2, (i % 2) ? ICSR_SS_RD : ICSR_SA_RD, w[4:0], 64'h0);
      cmp("other set", (i % 2) ? ~v : {40'h0, ~v[23:0]}, rd[2]);
    end
    fork
      begin
        go(0, ICSR_SS_RD, w[4:0], 64'h0);
        ta = $time;
      end
      begin
        go(1, ICSR_SS_RD, w[4:0], 64'h0);
        tb = $time;
      end
    join
    cmp("contended spacing", 64'h32, (ta > tb) ? ta - tb : tb - ta);
    cmp("contended data", v, rd[0]);
    $display("test shared done");
    w = 64'($urandom);
    go(0, ICSR_SEM_WR, 5'h0, w);
    go(1, ICSR_SEM_RD, 5'h0, 64'h0);
    cmp("sem group", {32'h0, w[31:0]}, rd[1]);
    go(1, ICSR_SEM_SET, 5'h3, 64'h0);
    go(0, ICSR_SEM_CLR, 5'h4, 64'h0);
    go(0, ICSR_SEM_CLR, 5'h9, 64'h0);
    fork
      begin
        go(0, ICSR_TEST_AND_SET_OP, 5'h9, 64'h0);
        ta = $time;
        go(0, ICSR_SEM_CLR, 5'h9, 64'h0);
      end
      begin
        go(1, ICSR_TEST_AND_SET_OP, 5'h9, 64'h0);
        tb = $time;
        go(1, ICSR_SEM_CLR, 5'h9, 64'h0);
      end
    join
    cmp("interlock", 64'h1, 64'(ta != tb));
    go(0, ICSR_TEST_AND_SET_OP, 5'h9, 64'h0);
    intr = 4'h1;
    go(0, ICSR_SEM_RD, 5'h0, 64'h0);
    intr = 4'h0;
    v = {32'h0, w[31:10], 1'b1, w[8:5], 2'b01, w[2:0]};
    cmp("sem bits", v, rd[0]);
    $display("test semaphore done");
    go(0, ICSR_SEM_SET, 5'h1, 64'h0);
    go(2, ICSR_SEM_SET, 5'h1, 64'h0);
    fork
      go(0, ICSR_TEST_AND_SET_OP, 5'h1, 64'h0);
      go(1, ICSR_TEST_AND_SET_OP, 5'h1, 64'h0);
      go(2, ICSR_TEST_AND_SET_OP, 5'h1, 64'h0);
      go(3, ICSR_TEST_AND_SET_OP, 5'h1, 64'h0);
      begin
        repeat (12) @(posedge clk);
        #2;
        cmp("deadlock", 64'h7, 64'(dl));
        intr = 4'hF;
        repeat (3) @(posedge clk);
        #2;
        intr = 4'h0;
      end
    join
    cmp("abort flags", 64'h3, 64'(ws_n));
    $display("test deadlock done");
    final_report();
  end
endmodule : inter_cpu_shared_regs_test
`default_nettype wire
